// [include/pll_words_regs.svh]
`ifndef PLL_WORDS_REGS_SVH
`define PLL_WORDS_REGS_SVH
// register select codes
`define SEL_INT_CAL 4'h0
`define SEL_MAIN_FRAC 4'h1
`define SEL_AUX_LOW 4'h2
`define SEL_PHASE 4'h3
`define SEL_AUX_HIGH 4'hD
// word layout
`define WORD_BITS 32
`define SEL_MSB 3
`define SEL_LSB 0
`define CAL_EN_BIT 21
`define PRESCALER_BIT 20
`define INT_MSB 19
`define INT_LSB 4
`define MAIN_FRACTION_NUMERATOR_MSB 27
`define MAIN_FRACTION_NUMERATOR_LSB 4
`define AUXF_LOW_MSB 31
`define AUXF_LOW_LSB 18
`define AUXM_LOW_MSB 17
`define AUXM_LOW_LSB 4
`define AUXF_HIGH_MSB 31
`define AUXF_HIGH_LSB 18
`define AUXM_HIGH_MSB 17
`define AUXM_HIGH_LSB 4
`define MOD_RST_DIS_BIT 30
`define RESYNC_EN_BIT 29
`define PHASE_STEP_BIT 28
`define PHASE_MSB 27
`define PHASE_LSB 4
`define AUX_HALF_W 14
`endif

// [include/pll_words_pkg.sv]
package pll_words_pkg;
  typedef enum logic {presc_4_5, presc_8_9} prescaler_t;
endpackage

// [include/serial_word_if.sv]
`timescale 1ns/1ps
`default_nettype none
// carries one received word and its load pulse
interface serial_word_if;
  logic [31:0] word;
  logic load;
  modport source (output word, output load);
  modport sink (input word, input load);
endinterface
`default_nettype wire

// [verilog/serial_shift_in.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pll_words_regs.svh"
module serial_shift_in (
  input wire logic sys_clk_i, // system clock
  input wire logic srst_i, // sync reset
  input wire logic sclk_i, // serial clock pin
  input wire logic sdata_i, // serial data pin
  input wire logic load_strobe_i, // load strobe pin
  serial_word_if.source out // word and load pulse
);
  logic [1:0] sclk_s, data_s, le_s;
  logic sclk_d, le_d;
  logic [`WORD_BITS-1:0] shreg;
  logic load;
  wire sclk_rise = sclk_s[1] & ~sclk_d;
  wire le_rise = le_s[1] & ~le_d;
  // two-stage synchronisers, then edge detect on the second stage only
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      sclk_s <= 2'h0; data_s <= 2'h0; le_s <= 2'h0; sclk_d <= 1'b0; le_d <= 1'b0;
    end else begin
      sclk_s <= {sclk_s[0], sclk_i};
      data_s <= {data_s[0], sdata_i};
      le_s <= {le_s[0], load_strobe_i};
      sclk_d <= sclk_s[1];
      le_d <= le_s[1];
    end
  end
  // msb first shift; the word out is the shift register itself, the load edge gives a one-cycle pulse
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      shreg <= 32'h0;
      load <= 1'b0;
    end else begin
      if (sclk_rise) shreg <= {shreg[`WORD_BITS-2:0], data_s[1]};
      load <= le_rise;
    end
  end
  assign out.word = shreg;
  assign out.load = load;
  a_load_follows_edge: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    le_rise |=> load) else $error("load pulse missing after strobe edge");
endmodule // serial_shift_in
`default_nettype wire

// [verilog/pll_frequency_phase_words.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pll_words_regs.svh"
// Functional notes
// - words shift in msb first on sclk rise; strobe rise latches them
// - low four bits of each word select the destination latch
// - fractions and aux modulus wait pending until word 0 is written
// - select code zero loads the integer and calibration word
// - calibration bit set: each word 0 write starts band search
// - calibration bit clear: word 0 write keeps current band
// - bit 20 of word 0 picks prescaler ratio
// - bits 19 to 4 of word 0 are the integer divide
// - code one loads main fraction; host zeros bits 31 to 28
// - bits 27 to 4 of word 1 are the 24-bit main fraction
// - aux fraction is high part shifted by 14 plus low part
// - aux modulus is high part times 2^14 plus low part
// - code three loads phase word; host zeros bit 31
// - word 0 write resets modulator unless reset disable is set
// - bit 29 of word 3 enables phase resync
// - phase step bit: each word 0 write advances phase by value
// - phase offset is value over 2^24 of a full cycle
module pll_frequency_phase_words (
  input wire logic sys_clk_i, // 20 MHz system clock
  input wire logic srst_i, // sync reset, active high
  input wire logic sclk_i, // serial clock from host
  input wire logic sdata_i, // serial data from host
  input wire logic load_strobe_i, // load strobe from host
  output logic [15:0] int_divide_o, // integer divide value
  output pll_words_pkg::prescaler_t prescaler_o, // prescaler ratio
  output logic [23:0] main_frac_o, // applied main fraction
  output logic [27:0] aux_frac_o, // applied aux fraction
  output logic [27:0] aux_mod_o, // applied aux modulus
  output logic cal_start_o, // band search start pulse
  output logic mod_reset_o, // modulator reset pulse
  output logic phase_step_o, // phase advance pulse
  output logic [23:0] phase_acc_o, // accumulated phase offset
  output logic resync_en_o, // phase resync enable
  output logic [23:0] phase_value_o // programmed phase value
);
  serial_word_if link ();
  serial_shift_in rx (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .sclk_i(sclk_i),
    .sdata_i(sdata_i),
    .load_strobe_i(load_strobe_i),
    .out(link)
  );

  // select decode on the received word
  wire [3:0] sel = link.word[`SEL_MSB:`SEL_LSB];
  wire wr0 = link.load && sel == `SEL_INT_CAL;
  wire wr1 = link.load && sel == `SEL_MAIN_FRAC;
  wire wr2 = link.load && sel == `SEL_AUX_LOW;
  wire wr3 = link.load && sel == `SEL_PHASE;
  wire wr13 = link.load && sel == `SEL_AUX_HIGH;
  wire cal_bit = link.word[`CAL_EN_BIT];

  // pending (buffered) halves
  logic [23:0] main_fraction_numerator_pend;
  logic [13:0] auxf_lo, auxm_lo, auxf_hi, auxm_hi;
  logic mod_rst_dis, phase_step_en;
  wire [27:0] auxf_comb = {auxf_hi, auxf_lo};
  wire [27:0] auxm_comb = {auxm_hi, auxm_lo};
  // the carry out of the phase sum is dropped on purpose: the offset wraps at a full cycle
  wire [24:0] phase_sum = phase_acc_o + phase_value_o;

  // pending writes; nothing reaches the modulator before word 0
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      main_fraction_numerator_pend <= 24'h0; auxf_lo <= 14'h0; auxm_lo <= 14'h0;
      auxf_hi <= 14'h0; auxm_hi <= 14'h0;
    end else begin
      if (wr1) main_fraction_numerator_pend <= link.word[`MAIN_FRACTION_NUMERATOR_MSB:`MAIN_FRACTION_NUMERATOR_LSB];
      if (wr2) begin
        auxf_lo <= link.word[`AUXF_LOW_MSB:`AUXF_LOW_LSB];
        auxm_lo <= link.word[`AUXM_LOW_MSB:`AUXM_LOW_LSB];
      end
      if (wr13) begin
        auxf_hi <= link.word[`AUXF_HIGH_MSB:`AUXF_HIGH_LSB];
        auxm_hi <= link.word[`AUXM_HIGH_MSB:`AUXM_HIGH_LSB];
      end
    end
  end

  // phase control word is not buffered: it steers the next word 0 write
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      mod_rst_dis <= 1'b0; resync_en_o <= 1'b0; phase_step_en <= 1'b0; phase_value_o <= 24'h0;
    end else if (wr3) begin
      mod_rst_dis <= link.word[`MOD_RST_DIS_BIT];
      resync_en_o <= link.word[`RESYNC_EN_BIT];
      phase_step_en <= link.word[`PHASE_STEP_BIT];
      phase_value_o <= link.word[`PHASE_MSB:`PHASE_LSB];
    end
  end

  // word 0 commits buffered values and fires actions
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      int_divide_o <= 16'h0; prescaler_o <= pll_words_pkg::presc_4_5;
      main_frac_o <= 24'h0; aux_frac_o <= 28'h0; aux_mod_o <= 28'h0;
      cal_start_o <= 1'b0; mod_reset_o <= 1'b0; phase_step_o <= 1'b0; phase_acc_o <= 24'h0;
    end else begin
      cal_start_o <= wr0 && cal_bit;
      mod_reset_o <= wr0 && !mod_rst_dis;
      phase_step_o <= wr0 && phase_step_en;
      if (wr0) begin
        int_divide_o <= link.word[`INT_MSB:`INT_LSB];
        prescaler_o <= pll_words_pkg::prescaler_t'(link.word[`PRESCALER_BIT]);
        main_frac_o <= main_fraction_numerator_pend;
        aux_frac_o <= auxf_comb;
        aux_mod_o <= auxm_comb;
        if (phase_step_en) phase_acc_o <= phase_sum[23:0];
      end
    end
  end

  a_cal_on_word0: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    wr0 |=> (cal_start_o == $past(cal_bit))) else $error("calibration start mismatch");
  a_cal_only_word0: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    cal_start_o |-> $past(wr0)) else $error("calibration without word 0");
  a_modrst_gated: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    mod_reset_o |-> $past(wr0) && !$past(mod_rst_dis)) else $error("bad modulator reset");
  a_frac_held: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    !wr0 |=> $stable(main_frac_o) && $stable(aux_mod_o)) else $error("buffered value moved early");
  a_int_loaded: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    wr0 |=> int_divide_o == $past(link.word[19:4])) else $error("integer not loaded");
  a_phase_adv: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    phase_step_o |-> phase_acc_o == $past(phase_acc_o) + phase_value_o) else $error("phase step wrong");
  a_presc_loaded: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    wr0 |=> prescaler_o == $past(link.word[20])) else $error("prescaler not loaded");
  a_main_fraction_numerator_commit: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    wr0 |=> main_frac_o == $past(main_fraction_numerator_pend)) else $error("main fraction not committed");
endmodule // pll_frequency_phase_words
`default_nettype wire

// [verif/host_serial_model.sv]
`timescale 1ns/1ps
`default_nettype none
// host end of the three-wire port; serial clock stands low between frames
module host_serial_model (
  input wire logic sys_clk_i, // paces the pins
  output logic sclk_o, // serial clock
  output logic sdata_o, // serial data
  output logic load_strobe_o // load strobe
);
  initial begin
    sclk_o = 1'b0;
    sdata_o = 1'b0;
    load_strobe_o = 1'b0;
  end
  // four system clocks per half period gives 200 ns
  task automatic half_wait();
    repeat (4) @(posedge sys_clk_i);
    #1;
  endtask
  // data moves a half period before each rise, so the synchronisers see it settled
  task automatic send(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      sdata_o = w[i];
      half_wait();
      sclk_o = 1'b1;
      half_wait();
      sclk_o = 1'b0;
    end
    sdata_o = ~w[0]; // idle line must not echo the last bit
    half_wait();
    load_strobe_o = 1'b1;
    half_wait();
    load_strobe_o = 1'b0;
  endtask
endmodule // host_serial_model
`default_nettype wire

// [verif/pll_frequency_phase_words_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module pll_frequency_phase_words_bench;
  logic sys_clk_i, srst_i, sclk, sdata, load_strobe, cal_start, mod_reset, phase_step, resync_en;
  logic [15:0] int_divide;
  pll_words_pkg::prescaler_t prescaler;
  logic [23:0] main_frac, phase_acc, phase_value;
  logic [27:0] aux_frac, aux_mod;
  int fail_count = 0, samples_checked = 0, cal_n = 0, rst_n = 0, step_n = 0;
  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  host_serial_model i_host_serial_model (.sys_clk_i(sys_clk_i), .sclk_o(sclk), .sdata_o(sdata),
    .load_strobe_o(load_strobe));
  pll_frequency_phase_words i_pll_frequency_phase_words (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
    .sclk_i(sclk), .sdata_i(sdata), .load_strobe_i(load_strobe), .int_divide_o(int_divide),
    .prescaler_o(prescaler), .main_frac_o(main_frac), .aux_frac_o(aux_frac), .aux_mod_o(aux_mod),
    .cal_start_o(cal_start), .mod_reset_o(mod_reset), .phase_step_o(phase_step),
    .phase_acc_o(phase_acc), .resync_en_o(resync_en), .phase_value_o(phase_value));
  // counting high cycles also catches a pulse that lasts too long
  always @(posedge sys_clk_i) begin
    if (cal_start === 1'b1) cal_n++;
    if (mod_reset === 1'b1) rst_n++;
    if (phase_step === 1'b1) step_n++;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // outputs land 4 clocks after the strobe rise; 8 more after its fall leaves margin
  task automatic wr(input logic [31:0] w);
    i_host_serial_model.send(w);
    repeat (8) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // whole run is about 2450 clocks
  initial begin
    #2000000;
    fail_count++;
    finish_test();
  end
  initial begin
    srst_i = 1'b1;
    repeat (6) @(posedge sys_clk_i);
    #1 srst_i = 1'b0;
    chk("divide after reset", 32'h0, int_divide);
    wr(32'h0ABCDE11);
    chk("main_frac pending", 32'h0, main_frac);
    wr({14'h0123, 14'h2345, 4'h2});
    wr({14'h0001, 14'h0002, 4'hD});
    wr({4'h2, 24'h123456, 4'h3});
    chk("resync_en", 32'h1, resync_en);
    chk("phase_value", 32'h123456, phase_value);
    wr({10'h0, 1'b1, 1'b1, 16'h4B, 4'h0});
    chk("int_divide", 32'h4B, int_divide);
    chk("prescaler", 32'h1, prescaler);
    chk("main_frac", 32'hABCDE1, main_frac);
    chk("aux_frac", {14'h0001, 14'h0123}, aux_frac);
    chk("aux_mod", {14'h0002, 14'h2345}, aux_mod);
    chk("cal pulses", 32'h1, cal_n);
    chk("modulator resets", 32'h1, rst_n);
    wr({4'h5, 24'hC00001, 4'h3});
    chk("resync_en off", 32'h0, resync_en);
    wr({10'h0, 1'b0, 1'b0, 16'h17, 4'h0});
    chk("prescaler", 32'h0, prescaler);
    chk("cal pulses", 32'h1, cal_n);
    chk("modulator resets", 32'h1, rst_n);
    chk("phase_acc", 32'hC00001, phase_acc);
    wr({28'h123ABC5, 4'h4});
    chk("int_divide kept", 32'h17, int_divide);
    wr({10'h0, 1'b0, 1'b0, 16'h17, 4'h0});
    chk("phase steps", 32'h2, step_n);
    chk("phase_acc wrap", 32'h800002, phase_acc);
    finish_test();
  end
endmodule // pll_frequency_phase_words_bench
`default_nettype wire
